// ===== hdl/dac_input_host.sv
// Host-side write sequencer for a 16-bit DAC with two byte latches and a DAC register.
// Assumes the converter's control pins are level-sensitive and active low, and that
// in byte modes the converter's 16 data pins are wired to one shared 8-bit bus.
`timescale 1ns/1ps
`include "dac_host_defs.svh"

module dac_input_host #(
  parameter int unsigned SETUP_CYC      = `SETUP_CYC,
  parameter int unsigned BYTE_PULSE_CYC = `BYTE_PULSE_CYC,
  parameter int unsigned LOAD_PULSE_CYC = `LOAD_PULSE_CYC,
  parameter int unsigned HOLD_CYC       = `HOLD_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 clkEn,
  input  wire logic                 cmdValid,
  output logic                      cmdReady,
  input  wire dac_host_pkg::cmd_s   cmd,
  output logic                      cmdDone,
  output dac_host_pkg::dacPins_s    pins
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    dac_host_pkg::seqState_e st;
    logic [3:0]              cnt;
    logic [1:0]              phase;
    dac_host_pkg::cmd_s      cmd;
    logic                    done;
    dac_host_pkg::dacPins_s  pins;
  } state_s;

  // Counters are four bits wide: a timing count above 16 cycles would wrap
  localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);
  localparam logic [3:0] HOLD_LAST  = 4'(HOLD_CYC - 1);
  localparam logic [3:0] BYTE_LAST  = 4'(BYTE_PULSE_CYC - 1);
  localparam logic [3:0] LOAD_LAST  = 4'(LOAD_PULSE_CYC - 1);
  // A strobe that also pulses the load pin must satisfy the longer of both widths
  localparam logic [3:0] SYNC_LAST  = (LOAD_LAST > BYTE_LAST) ? LOAD_LAST : BYTE_LAST;

  state_s s_q;
  state_s s_d;

  // --------------------------------------------------------------------------
  // Phase plan
  // --------------------------------------------------------------------------
  function automatic dac_host_pkg::phaseKind_e phaseKind(input dac_host_pkg::cmd_s c,
                                                         input logic [1:0]         ph);
    dac_host_pkg::phaseKind_e firstB;
    dac_host_pkg::phaseKind_e secondB;
    firstB  = c.upperFirst ? dac_host_pkg::KIND_UPPER : dac_host_pkg::KIND_LOWER;
    secondB = c.upperFirst ? dac_host_pkg::KIND_LOWER : dac_host_pkg::KIND_UPPER;
    phaseKind = dac_host_pkg::KIND_NONE;
    case (c.mode)
      dac_host_pkg::MODE_WORD: begin
        if (ph == 2'h0) phaseKind = dac_host_pkg::KIND_WORD;
      end
      dac_host_pkg::MODE_LOAD_ONLY: begin
        if (ph == 2'h0) phaseKind = dac_host_pkg::KIND_LOAD;
      end
      dac_host_pkg::MODE_BYTES_SYNC,
      dac_host_pkg::MODE_BYTES_SEPARATE: begin
        if (ph == 2'h0) phaseKind = firstB;
        else if (ph == 2'h1) phaseKind = secondB;
        else if (ph == 2'h2 && c.mode == dac_host_pkg::MODE_BYTES_SEPARATE) begin
          phaseKind = dac_host_pkg::KIND_LOAD;
        end
      end
      default: phaseKind = dac_host_pkg::KIND_NONE;
    endcase
  endfunction

  // Data placed on the pins for a phase; a byte goes out on both halves of the bus
  function automatic logic [15:0] phaseData(input dac_host_pkg::cmd_s       c,
                                            input dac_host_pkg::phaseKind_e k,
                                            input logic [15:0]              cur);
    case (k)
      dac_host_pkg::KIND_UPPER: phaseData = {c.word[15:8], c.word[15:8]};
      dac_host_pkg::KIND_LOWER: phaseData = {c.word[7:0], c.word[7:0]};
      dac_host_pkg::KIND_WORD:  phaseData = c.word;
      default:                  phaseData = cur;
    endcase
  endfunction

  // Down-counter step shared by every timed state
  function automatic logic [3:0] countDown(input logic [3:0] c);
    countDown = c - 4'h1;
  endfunction

  // Phase three is never planned, so the wrap of this step is harmless
  function automatic logic [1:0] nextPhase(input logic [1:0] p);
    nextPhase = 2'(p + 2'h1);
  endfunction

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  dac_host_pkg::phaseKind_e kindNow;
  dac_host_pkg::phaseKind_e kindNext;
  logic                     lastByte;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    kindNow  = phaseKind(s_q.cmd, s_q.phase);
    kindNext = phaseKind(s_q.cmd, nextPhase(s_q.phase));
    lastByte = (s_q.cmd.mode == dac_host_pkg::MODE_BYTES_SYNC) && (s_q.phase == 2'h1);
    case (s_q.st)
      dac_host_pkg::ST_IDLE: begin
        if (cmdValid) begin
          s_d.cmd   = cmd;
          s_d.phase = 2'h0;
          s_d.cnt   = SETUP_LAST;
          s_d.st    = dac_host_pkg::ST_SETUP;
          // Decoded address on select for the whole write; enables stay high here
          s_d.pins.chipSelectN      = 1'b0;
          s_d.pins.upperByteEnableN = 1'b1;
          s_d.pins.lowerByteEnableN = 1'b1;
          // Word mode keeps the DAC register open; others close it before data moves
          s_d.pins.registerLoadN = (cmd.mode != dac_host_pkg::MODE_WORD);
          s_d.pins.dacData = phaseData(cmd, phaseKind(cmd, 2'h0), s_q.pins.dacData);
        end
      end
      dac_host_pkg::ST_SETUP: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st = dac_host_pkg::ST_STROBE;
          case (kindNow)
            dac_host_pkg::KIND_UPPER: begin
              s_d.pins.upperByteEnableN = 1'b0;
              s_d.pins.registerLoadN    = ~lastByte;
              s_d.cnt = lastByte ? SYNC_LAST : BYTE_LAST;
            end
            dac_host_pkg::KIND_LOWER: begin
              s_d.pins.lowerByteEnableN = 1'b0;
              s_d.pins.registerLoadN    = ~lastByte;
              s_d.cnt = lastByte ? SYNC_LAST : BYTE_LAST;
            end
            dac_host_pkg::KIND_WORD: begin
              // Both enables with load already low: every latch transparent
              s_d.pins.upperByteEnableN = 1'b0;
              s_d.pins.lowerByteEnableN = 1'b0;
              s_d.cnt = BYTE_LAST;
            end
            default: begin
              s_d.pins.registerLoadN = 1'b0;
              s_d.cnt = LOAD_LAST;
            end
          endcase
        end else begin
          s_d.cnt = countDown(s_q.cnt);
        end
      end
      dac_host_pkg::ST_STROBE: begin
        if (s_q.cnt == 4'h0) begin
          // Closing edge: latches keep what they saw; data stays put through hold
          s_d.pins.upperByteEnableN = 1'b1;
          s_d.pins.lowerByteEnableN = 1'b1;
          if (s_q.cmd.mode != dac_host_pkg::MODE_WORD) s_d.pins.registerLoadN = 1'b1;
          s_d.cnt = HOLD_LAST;
          s_d.st  = dac_host_pkg::ST_HOLD;
        end else begin
          s_d.cnt = countDown(s_q.cnt);
        end
      end
      dac_host_pkg::ST_HOLD: begin
        if (s_q.cnt != 4'h0) begin
          s_d.cnt = countDown(s_q.cnt);
        end else if (kindNext != dac_host_pkg::KIND_NONE) begin
          s_d.phase        = nextPhase(s_q.phase);
          s_d.cnt          = SETUP_LAST;
          s_d.st           = dac_host_pkg::ST_SETUP;
          s_d.pins.dacData = phaseData(s_q.cmd, kindNext, s_q.pins.dacData);
        end else begin
          s_d.pins.chipSelectN = 1'b1;
          s_d.done             = 1'b1;
          s_d.st               = dac_host_pkg::ST_IDLE;
        end
      end
      default: s_d.st = dac_host_pkg::ST_IDLE;
    endcase
  end

  // Reset acts even while the enable is low, so a frozen host can still be cleared
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_q                       <= '0;
      s_q.st                    <= dac_host_pkg::ST_IDLE;
      s_q.pins.chipSelectN      <= `PIN_CTRL_IDLE;
      s_q.pins.upperByteEnableN <= `PIN_CTRL_IDLE;
      s_q.pins.lowerByteEnableN <= `PIN_CTRL_IDLE;
      s_q.pins.registerLoadN    <= `PIN_CTRL_IDLE;
      s_q.pins.dacData          <= `PIN_DATA_RESET;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Ready is combinational so a new command can be taken in the cycle done shows
  assign cmdReady = clkEn && (s_q.st == dac_host_pkg::ST_IDLE);
  assign cmdDone  = s_q.done;
  assign pins     = s_q.pins;

endmodule

// ===== pkg/dac_host_defs.svh
// Timing figures and reset values for the double-buffered DAC input host.
// Assumes a single system clock whose period is given below in nanoseconds.
`ifndef DAC_HOST_DEFS_SVH
`define DAC_HOST_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     50

// ----------------------------------------------------------------------------
// Interface times in ns, as printed
// ----------------------------------------------------------------------------
`define SETUP_NS          60
`define BYTE_PULSE_NS     60
`define LOAD_PULSE_NS     70
`define HOLD_NS           20

// Least times round up to whole cycles, never below one
`define CEIL_CYC(ns)      ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                           (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define SETUP_CYC         `CEIL_CYC(`SETUP_NS)
`define BYTE_PULSE_CYC    `CEIL_CYC(`BYTE_PULSE_NS)
`define LOAD_PULSE_CYC    `CEIL_CYC(`LOAD_PULSE_NS)
`define HOLD_CYC          `CEIL_CYC(`HOLD_NS)

// ----------------------------------------------------------------------------
// Pin levels after reset: all controls released, data at zero scale
// ----------------------------------------------------------------------------
`define PIN_CTRL_IDLE     1'h1
`define PIN_DATA_RESET    16'h0000

`endif

// ===== pkg/dac_host_pkg.sv
// Types shared by the DAC input host and its surroundings.
// Assumes the timing header is compiled alongside; this package holds types only.
package dac_host_pkg;

  // --------------------------------------------------------------------------
  // Command
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_WORD,
    MODE_BYTES_SYNC,
    MODE_BYTES_SEPARATE,
    MODE_LOAD_ONLY
  } writeMode_e;

  typedef struct packed {
    writeMode_e  mode;
    logic        upperFirst;
    logic [15:0] word;
  } cmd_s;

  // --------------------------------------------------------------------------
  // Pins toward the converter, all active low except data
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        chipSelectN;
    logic        upperByteEnableN;
    logic        lowerByteEnableN;
    logic        registerLoadN;
    logic [15:0] dacData;
  } dacPins_s;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } seqState_e;

  typedef enum logic [2:0] {
    KIND_UPPER,
    KIND_LOWER,
    KIND_WORD,
    KIND_LOAD,
    KIND_NONE
  } phaseKind_e;

endpackage

// ===== tb/dac_device_model.sv
// Behavioural model of the converter's two byte latches and DAC register.
// Assumes the 8-bit byte bus is wired to both data halves, as the host does.
`timescale 1ns/1ps
module dac_device_model (
  input wire dac_host_pkg::dacPins_s pins,
  output logic [15:0]                dacOut
);
  logic [7:0] upperByte_q;
  logic [7:0] lowerByte_q;
  logic       upperOpen;
  logic       lowerOpen;
  logic       loadOpen;
  // Select gates every latch; controls act low and by level
  assign upperOpen = !pins.chipSelectN && !pins.upperByteEnableN;
  assign lowerOpen = !pins.chipSelectN && !pins.lowerByteEnableN;
  assign loadOpen  = !pins.chipSelectN && !pins.registerLoadN;
  // Closed latches keep their value whatever the data pins do
  always_latch if (upperOpen) upperByte_q = pins.dacData[15:8];
  always_latch if (lowerOpen) lowerByte_q = pins.dacData[7:0];
  // Chained latches pass data straight through when all are open
  always_latch if (loadOpen) dacOut = {upperByte_q, lowerByte_q};
endmodule

// ===== tb/dac_host_monitor.sv
// Concurrent checks on the pins and handshake of the DAC input host.
// Assumes it is bound to dac_input_host and sees its ports only.
`timescale 1ns/1ps
module dac_host_monitor (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   clkEn,
  input wire logic                   cmdValid,
  input wire logic                   cmdReady,
  input wire dac_host_pkg::cmd_s     cmd,
  input wire logic                   cmdDone,
  input wire dac_host_pkg::dacPins_s pins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic        take;
  logic [15:0] takenWord_q;
  assign take = cmdValid && cmdReady;
  always_ff @(posedge clk_sys) begin
    if (take) takenWord_q <= cmd.word;
  end
  a_reset_idle: assert property (disable iff (1'b0) !rstn |=> pins == {4'hF, 16'h0000} && !cmdDone)
    else $error("pins not idle after reset");
  a_ready_enable: assert property (!clkEn |-> !cmdReady)
    else $error("ready while clock enable low");
  a_enable_select: assert property (!pins.upperByteEnableN || !pins.lowerByteEnableN |-> !pins.chipSelectN)
    else $error("byte enable without select");
  a_data_held: assert property (!pins.upperByteEnableN || !pins.lowerByteEnableN |=> $stable(pins.dacData))
    else $error("data changed as enable rose");
  a_both_load: assert property (!pins.upperByteEnableN && !pins.lowerByteEnableN |-> !pins.registerLoadN)
    else $error("word strobe without load low");
  // A reset in mid-command also raises the controls, so edges out of reset do not count
  a_load_release: assert property ($rose(pins.registerLoadN) && $past(rstn) |->
    pins.upperByteEnableN && pins.lowerByteEnableN)
    else $error("load released with enable low");
  a_upper_width: assert property ($fell(pins.upperByteEnableN) |=> !pins.upperByteEnableN)
    else $error("upper enable pulse too short");
  a_word_start: assert property (take && cmd.mode == dac_host_pkg::MODE_WORD |->
    ##[1:2] (!pins.chipSelectN && !pins.registerLoadN && pins.dacData == takenWord_q))
    else $error("word write did not start");
  a_done_select: assert property ($rose(pins.chipSelectN) && $past(rstn) |-> cmdDone)
    else $error("select released without done");
endmodule
bind dac_input_host dac_host_monitor dac_host_monitor_i (
  .clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .cmd(cmd), .cmdDone(cmdDone), .pins(pins));

// ===== tb/tb.sv
// Self-checking bench: DAC input host driving the latch model.
// Assumes default timing parameters and a 50 ns clock.
`timescale 1ns/1ps
module tb;
  typedef struct {
    dac_host_pkg::writeMode_e m;
    logic                     uf;
    logic [15:0]              w;
    logic [15:0]              e;
  } row_s;
  logic                   clk_sys;
  logic                   rstn;
  logic                   clkEn;
  logic                   cmdValid;
  logic                   cmdReady;
  logic                   cmdDone;
  dac_host_pkg::cmd_s     cmd;
  dac_host_pkg::dacPins_s pins;
  dac_host_pkg::dacPins_s saved;
  logic [15:0]            dacOut;
  int                     miscompares = 0;
  int                     num_checks = 0;
  int                     cycles = 0;
  row_s                   rows [6] = '{
    '{dac_host_pkg::MODE_WORD, 1'b0, 16'h0000, 16'h0000},
    '{dac_host_pkg::MODE_WORD, 1'b0, 16'hFFFF, 16'hFFFF},
    '{dac_host_pkg::MODE_BYTES_SYNC, 1'b1, 16'h1234, 16'h1234},
    '{dac_host_pkg::MODE_BYTES_SYNC, 1'b0, 16'hA55A, 16'hA55A},
    '{dac_host_pkg::MODE_BYTES_SEPARATE, 1'b1, 16'h8080, 16'h8080},
    '{dac_host_pkg::MODE_BYTES_SEPARATE, 1'b0, 16'h7F01, 16'h7F01}};

  dac_input_host dac_input_host_i (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmd(cmd), .cmdDone(cmdDone), .pins(pins));
  dac_device_model dac_device_model_i (.pins(pins), .dacOut(dacOut));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Output must not move before the register load is seen low
  task automatic send(input dac_host_pkg::cmd_s c);
    int          n;
    logic        held;
    logic [15:0] prev;
    n = 0;
    held = (c.mode != dac_host_pkg::MODE_WORD);
    prev = dacOut;
    cmdValid <= 1'b1;
    cmd <= c;
    do @(posedge clk_sys); while (cmdReady !== 1'b1 && ++n < 50);
    cmdValid <= 1'b0;
    do begin
      @(posedge clk_sys);
      held = held && pins.registerLoadN;
      if (held) check("heldOut", dacOut, prev);
    end while (cmdDone !== 1'b1 && ++n < 100);
    check("cmdDone", cmdDone, 1'b1);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rstn = 1'b0;
    clkEn = 1'b1;
    cmdValid = 1'b0;
    cmd = '0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check("pinsIdle", pins, {4'hF, 16'h0000});
    foreach (rows[i]) begin
      send('{rows[i].m, rows[i].uf, rows[i].w});
      check("dacOut", dacOut, rows[i].e);
    end
    // Abort after the upper byte: first rank now mixes old and new bytes
    cmdValid <= 1'b1;
    cmd <= '{dac_host_pkg::MODE_BYTES_SEPARATE, 1'b1, 16'h1200};
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check("pinsAbort", {cmdDone, pins}, {1'b0, 4'hF, 16'h0000});
    check("abortOut", dacOut, 16'h7F01);
    send('{dac_host_pkg::MODE_LOAD_ONLY, 1'b0, 16'h0000});
    check("loadOnly", dacOut, 16'h1201);
    // Clock enable low freezes the pins mid command
    fork
      send('{dac_host_pkg::MODE_BYTES_SYNC, 1'b1, 16'h00FF});
      begin
        repeat (5) @(posedge clk_sys);
        clkEn <= 1'b0;
        @(posedge clk_sys);
        saved = pins;
        repeat (2) begin
          @(posedge clk_sys);
          check("frozen", pins, saved);
        end
        clkEn <= 1'b1;
      end
    join
    check("syncOut", dacOut, 16'h00FF);
    report_and_stop();
  end
endmodule
